// ---- faid_map.svh ----
`ifndef FAID_MAP_SVH
`define FAID_MAP_SVH
// low address patterns for identification reads (A3..A0)
`define FAID_PAT_MFR          4'h0
`define FAID_PAT_DEV1         4'h1
`define FAID_PAT_DEV2         4'he
`define FAID_PAT_DEV3         4'hf
`define FAID_PAT_PROT         4'h2
`define FAID_PAT_SECURED      4'h3
// address bit positions
`define FAID_BIT_HV           9
`define FAID_BIT_A7           7
`define FAID_BIT_A6           6
`define FAID_SECT_LSB         12
`define FAID_BANK_LSB         20
// protection and secured-region answers
`define FAID_PROT_ON          16'h0001
`define FAID_PROT_OFF         16'h0000
`define FAID_SECURED_MASK     8'hc0
`define FAID_SECURED_BASE     23'h000000
`define FAID_SECURED_USER     23'h000040
// identification command writes (address, data)
`define FAID_CMD_A1           23'h000555
`define FAID_CMD_D1           16'h00aa
`define FAID_CMD_A2           23'h0002aa
`define FAID_CMD_D2           16'h0055
`define FAID_CMD_A3           23'h000555
`define FAID_CMD_D3           16'h0090
`define FAID_CMD_EXIT         16'h00f0
// bus timing: access and strobe times in ns, converted to cycles at 100 MHz
`define FAID_CLK_NS           10
`define FAID_ACCESS_NS        120
`define FAID_ACCESS_CYC       ((`FAID_ACCESS_NS + `FAID_CLK_NS - 1) / `FAID_CLK_NS)
`define FAID_SETUP_NS         20
`define FAID_SETUP_CYC        ((`FAID_SETUP_NS + `FAID_CLK_NS - 1) / `FAID_CLK_NS)
`endif

// ---- faid_pkg.sv ----
package faid_pkg;
	typedef enum logic [1:0]
	{
		FAID_Q_MFR,
		FAID_Q_DEV,
		FAID_Q_PROT,
		FAID_Q_SECURED
	} faid_query_e;
	typedef enum logic [1:0]
	{
		FAID_M_HV,
		FAID_M_CMD,
		FAID_M_EXIT
	} faid_method_e;
endpackage : faid_pkg

// ---- faid_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "faid_map.svh"

// Operation
// - For the high-voltage method the host holds the high voltage on A9 and sets the other address pins before reading; here both are set as flash_oe_n falls.
// - For a protection query the host puts the sector address on the top address bits and gets 0001h if protected, 0000h if not.
// - Manufacturer identity is at A3..A0 LLLL and the three device identity words at LLLH, HHHL, HHHH with A7 and A6 low.
// - Each identification read is made with chip select low, output enable low and write enable high.
module faid_host
	import faid_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        req_valid,
	input  wire logic [1:0]  req_query,
	input  wire logic [1:0]  req_method,
	input  wire logic [1:0]  req_index,
	input  wire logic [10:0] req_sector,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic [15:0]      rsp_data,
	output logic             rsp_flag,
	output logic [22:0]      flash_addr,
	input  wire logic [15:0] flash_dq_in,
	output logic [15:0]      flash_dq_out,
	output logic             flash_dq_oe_n,
	output logic             flash_cs_n,
	output logic             flash_oe_n,
	output logic             flash_we_n,
	output logic             flash_hv_en
);

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_WRITE,
		ST_GAP,
		ST_READ,
		ST_DONE
	} faid_state_e;

	faid_state_e  state_q;
	logic [3:0]   cnt_q;
	logic [1:0]   wr_idx_q;
	logic [1:0]   query_q;
	logic [1:0]   method_q;
	logic [1:0]   index_q;
	logic [10:0]  sector_q;
	logic [15:0]  dq_s1_q;
	logic [15:0]  dq_s2_q;

	// low pattern for a read, chosen by query kind and device id index
	function automatic logic [3:0] low_pattern(input logic [1:0] q, input logic [1:0] idx);
		logic [3:0] p;
		p = `FAID_PAT_MFR;
		if (q == FAID_Q_DEV)
		begin
			p = (idx == 2'h0) ? `FAID_PAT_DEV1 : ((idx == 2'h1) ? `FAID_PAT_DEV2 : `FAID_PAT_DEV3);
		end
		else if (q == FAID_Q_PROT)
		begin
			p = `FAID_PAT_PROT;
		end
		else if (q == FAID_Q_SECURED)
		begin
			p = `FAID_PAT_SECURED;
		end
		return p;
	endfunction : low_pattern

	// full read address: sector on top bits for protection queries and command-method reads, A7/A6 low always
	function automatic logic [22:0] read_addr(input logic [1:0] q, input logic [1:0] idx, input logic [10:0] sec);
		logic [22:0] a;
		a = 23'h000000;
		a[3:0] = low_pattern(q, idx);
		a[`FAID_BIT_A7] = 1'b0;
		a[`FAID_BIT_A6] = 1'b0;
		if (q == FAID_Q_PROT || method_q == FAID_M_CMD)
		begin
			a[22:`FAID_SECT_LSB] = sec;
		end
		return a;
	endfunction : read_addr

	// command write address for step i; bank bits go on the third write
	function automatic logic [22:0] cmd_addr(input logic [1:0] i, input logic [10:0] sec);
		logic [22:0] a;
		a = (i == 2'h0) ? `FAID_CMD_A1 : ((i == 2'h1) ? `FAID_CMD_A2 : `FAID_CMD_A3);
		if (i == 2'h2)
		begin
			a[22:`FAID_BANK_LSB] = sec[10:8];
		end
		return a;
	endfunction : cmd_addr

	// two-flop sync of data pins; only the second stage is read
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end
		else
		begin
			dq_s1_q <= flash_dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// sequencer: optional command writes, then one read (or exit write)
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q   <= ST_IDLE;
			cnt_q     <= 4'h0;
			wr_idx_q  <= 2'h0;
			query_q   <= 2'h0;
			method_q  <= 2'h0;
			index_q   <= 2'h0;
			sector_q  <= 11'h000;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (req_valid)
					begin
						query_q  <= req_query;
						method_q <= req_method;
						index_q  <= req_index;
						sector_q <= req_sector;
						wr_idx_q <= 2'h0;
						cnt_q    <= 4'h0;
						state_q  <= (req_method == FAID_M_HV) ? ST_READ : ST_WRITE;
					end
				end
				ST_WRITE:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'(`FAID_SETUP_CYC))
					begin
						cnt_q   <= 4'h0;
						state_q <= ST_GAP;
					end
				end
				ST_GAP:
				begin
					// exit is a single write; identification is three
					if (method_q == FAID_M_EXIT || wr_idx_q == 2'h2)
					begin
						state_q <= (method_q == FAID_M_EXIT) ? ST_DONE : ST_READ;
					end
					else
					begin
						wr_idx_q <= wr_idx_q + 2'h1;
						state_q  <= ST_WRITE;
					end
				end
				ST_READ:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'(`FAID_ACCESS_CYC + 2))
					begin
						state_q <= ST_DONE; // sync delay of two added to access time
					end
				end
				ST_DONE:
				begin
					state_q <= ST_IDLE;
				end
				// three state bits leave unused codes; fall back to idle
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// pin drive, all registered
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flash_addr    <= 23'h000000;
			flash_dq_out  <= 16'h0000;
			flash_dq_oe_n <= 1'b1;
			flash_cs_n    <= 1'b1;
			flash_oe_n    <= 1'b1;
			flash_we_n    <= 1'b1;
			flash_hv_en   <= 1'b0;
		end
		else
		begin
			flash_cs_n    <= !(state_q == ST_WRITE || state_q == ST_READ);
			flash_oe_n    <= !(state_q == ST_READ);
			flash_we_n    <= !(state_q == ST_WRITE && cnt_q != 4'(`FAID_SETUP_CYC));
			flash_dq_oe_n <= !(state_q == ST_WRITE);
			// high voltage held across the whole read, dropped after so the device leaves the mode
			flash_hv_en   <= (state_q == ST_READ && method_q == FAID_M_HV);
			if (state_q == ST_WRITE)
			begin
				flash_addr   <= cmd_addr(wr_idx_q, sector_q);
				flash_dq_out <= (method_q == FAID_M_EXIT) ? `FAID_CMD_EXIT :
					((wr_idx_q == 2'h0) ? `FAID_CMD_D1 : ((wr_idx_q == 2'h1) ? `FAID_CMD_D2 : `FAID_CMD_D3));
			end
			else if (state_q == ST_READ)
			begin
				flash_addr <= read_addr(query_q, index_q, sector_q);
			end
		end
	end

	// answer: low byte only, flag decoded per query
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsp_valid <= 1'b0;
			rsp_data  <= 16'h0000;
			rsp_flag  <= 1'b0;
			req_ready <= 1'b0;
		end
		else
		begin
			req_ready <= (state_q == ST_IDLE) && !req_valid;
			rsp_valid <= (state_q == ST_READ && cnt_q == 4'(`FAID_ACCESS_CYC + 2)) ||
				(state_q == ST_GAP && method_q == FAID_M_EXIT);
			if (state_q == ST_READ && cnt_q == 4'(`FAID_ACCESS_CYC + 2))
			begin
				rsp_data <= {8'h00, dq_s2_q[7:0]};
				if (query_q == FAID_Q_PROT)
				begin
					rsp_flag <= ({8'h00, dq_s2_q[7:0]} == `FAID_PROT_ON);
				end
				else
				begin
					rsp_flag <= ((dq_s2_q[7:0] & `FAID_SECURED_MASK) == `FAID_SECURED_MASK);
				end
			end
		end
	end

endmodule : faid_host
`default_nettype wire

// ---- faid_flash_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module faid_flash_model
#(
	parameter logic [15:0] MFR_ID    = 16'h00a5,         // arbitrary identity value
	parameter logic [47:0] DEV_ID    = 48'h001100220033, // arbitrary identity value
	parameter logic [10:0] PROT_SECT = 11'h7f8,
	parameter int          ACC_NS    = 60
)
(
	input  wire logic [22:0] addr,
	input  wire logic [15:0] dq_in,
	input  wire logic        cs_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        hv_on,
	output logic      [15:0] dq_out
);
	logic [1:0]  step_q   = 2'd0;
	logic        cmd_id_q = 1'b0;
	logic [2:0]  bank_q   = 3'd0;
	logic [15:0] code;
	// unlock words are counted on write strobes with the chip selected; a word out of order starts over
	// the strobe settling high out of reset is no write, so an unselected edge is ignored
	always @(posedge we_n)
	begin
		if (!cs_n)
		begin
			if (dq_in[7:0] == 8'hf0)
				cmd_id_q = 1'b0;
			if (step_q == 2'd2 && dq_in[7:0] == 8'h90)
			begin
				cmd_id_q = 1'b1;
				bank_q = addr[22:20];
			end
			step_q = (step_q == 2'd0 && dq_in[7:0] == 8'haa) ? 2'd1 :
				(step_q == 2'd1 && dq_in[7:0] == 8'h55) ? 2'd2 : 2'd0;
		end
	end
	// id codes only in the selected bank or under high voltage, on the low byte
	always_comb
	begin
		code = addr[15:0] ^ 16'h5a5a;
		if (hv_on || (cmd_id_q && addr[22:20] == bank_q))
			case (addr[3:0])
				4'h0: code = {8'h00, MFR_ID[7:0]};
				4'h1: code = {8'h00, DEV_ID[39:32]};
				4'he: code = {8'h00, DEV_ID[23:16]};
				4'hf: code = {8'h00, DEV_ID[7:0]};
				4'h2: code = (addr[22:12] == PROT_SECT) ? 16'h0001 : 16'h0000;
				4'h3: code = 16'h00c0; // both halves of the secured region locked
				default: code = 16'h0000;
			endcase
	end
	// a released bus shows the inverse so a stale sample cannot pass
	assign #(ACC_NS) dq_out = (!cs_n && !oe_n) ? code : ~code;
endmodule : faid_flash_model
`default_nettype wire

// ---- faid_host_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module faid_host_chk
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        req_valid,
	input wire logic [1:0]  req_query,
	input wire logic [1:0]  req_method,
	input wire logic [10:0] req_sector,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic        rsp_flag,
	input wire logic [22:0] flash_addr,
	input wire logic        flash_cs_n,
	input wire logic        flash_oe_n,
	input wire logic        flash_we_n,
	input wire logic        flash_hv_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// high-voltage read: voltage first, answer within a bounded wait
	sequence hv_take;
		$rose(req_valid) && req_method == 2'd0;
	endsequence
	sequence hv_answer;
		##[1:4] flash_hv_en ##[1:30] rsp_valid;
	endsequence
	AST_HV_ANSWER: assert property (hv_take |-> hv_answer)
		else $error("high-voltage read not answered in time");
	AST_READ_STROBES: assert property (!flash_oe_n |-> !flash_cs_n && flash_we_n)
		else $error("read strobes wrong");
	AST_A7_A6_LOW: assert property (!flash_oe_n |-> flash_addr[7:6] == 2'b00)
		else $error("a7 or a6 high in id read");
	AST_HV_PATTERN: assert property (flash_hv_en && !flash_oe_n |->
		flash_addr[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'he, 4'hf})
		else $error("bad id pattern under high voltage");
	AST_PROT_SECTOR: assert property (!flash_oe_n && flash_addr[3:0] == 4'h2 |-> flash_addr[22:12] == req_sector)
		else $error("sector missing on top address bits");
	AST_PROT_FLAG: assert property (rsp_valid && req_query == 2'd2 |-> rsp_flag == (rsp_data == 16'h0001))
		else $error("protection flag wrong");
endmodule : faid_host_chk
bind faid_host faid_host_chk faid_host_chk_inst (.core_clk, .rst_n, .req_valid, .req_query, .req_method,
	.req_sector, .rsp_valid, .rsp_data, .rsp_flag, .flash_addr, .flash_cs_n, .flash_oe_n, .flash_we_n, .flash_hv_en);
`default_nettype wire

// ---- faid_host_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", what, exp, got); end end
module faid_host_tb import faid_pkg::*;;
	localparam logic [15:0] MFR  = 16'h00a5;         // arbitrary identity value
	localparam logic [47:0] DEV  = 48'h001100220033; // arbitrary identity value
	localparam logic [10:0] PROT = 11'h7f8;
	logic        core_clk, rst_n, req_valid, req_ready, rsp_valid, rsp_flag;
	logic        flash_dq_oe_n, flash_cs_n, flash_oe_n, flash_we_n, flash_hv_en;
	logic [1:0]  req_query, req_method, req_index;
	logic [10:0] req_sector;
	logic [15:0] rsp_data, flash_dq_out, flash_dq_in, dev_dq;
	logic [22:0] flash_addr;
	int          err_count, n_checks;
	// shared data wire: the host wins while its enable is low
	assign flash_dq_in = !flash_dq_oe_n ? flash_dq_out : dev_dq;
	faid_host faid_host_inst (.core_clk, .rst_n, .req_valid, .req_query, .req_method, .req_index, .req_sector,
		.req_ready, .rsp_valid, .rsp_data, .rsp_flag, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe_n,
		.flash_cs_n, .flash_oe_n, .flash_we_n, .flash_hv_en);
	faid_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .PROT_SECT(PROT), .ACC_NS(60)) faid_flash_model_inst
		(.addr(flash_addr), .dq_in(flash_dq_in), .cs_n(flash_cs_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
		.hv_on(flash_hv_en), .dq_out(dev_dq));
	task automatic wrap_up();
		if (err_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	// request held until the answer pulse, then released; exit carries no data
	task automatic request(input logic [1:0] m, input logic [1:0] q, input logic [1:0] ix,
		input logic [10:0] s, input logic [15:0] exp_d);
		int n;
		@(negedge core_clk);
		`CHK("ready", 1'b1, req_ready)
		req_method = m;
		req_query = q;
		req_index = ix;
		req_sector = s;
		req_valid = 1'b1;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 100);
		req_valid = 1'b0;
		if (n >= 100)
		begin
			err_count++;
			wrap_up();
		end
		`CHK("busy", 1'b0, req_ready)
		if (m != 2'd2)
		begin
			`CHK("data", exp_d, rsp_data)
			`CHK("flag", (q == 2'd2) ? (exp_d == 16'h0001) : (&exp_d[7:6]), rsp_flag)
		end
		repeat (3) @(negedge core_clk);
	endtask : request
	task automatic t_hv_ids();
		request(FAID_M_HV, FAID_Q_MFR, 2'd0, 11'h000, {8'h00, MFR[7:0]});
		for (int i = 0; i < 3; i++)
			request(FAID_M_HV, FAID_Q_DEV, 2'(i), 11'h000, {8'h00, DEV[39 - 16 * i -: 8]});
	endtask : t_hv_ids
	// neighbouring 4 Kword sector tells a full eleven-bit decode from a short one
	task automatic t_protect();
		request(FAID_M_HV, FAID_Q_PROT, 2'd0, PROT, 16'h0001);
		request(FAID_M_HV, FAID_Q_PROT, 2'd0, PROT + 11'd1, 16'h0000);
		request(FAID_M_HV, FAID_Q_SECURED, 2'd0, 11'h000, 16'h00c0);
	endtask : t_protect
	task automatic t_cmd();
		request(FAID_M_CMD, FAID_Q_MFR, 2'd0, 11'h700, {8'h00, MFR[7:0]});
		request(FAID_M_CMD, FAID_Q_PROT, 2'd0, PROT, 16'h0001);
		request(FAID_M_EXIT, FAID_Q_MFR, 2'd0, 11'h000, 16'h0000);
		`CHK("mode", 1'b0, faid_flash_model_inst.cmd_id_q)
	endtask : t_cmd
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		{rst_n, req_valid, req_query, req_method, req_index, req_sector} = '0;
		err_count = 0;
		n_checks = 0;
		repeat (10) @(negedge core_clk);
		rst_n = 1'b1;
		t_hv_ids();
		t_protect();
		t_cmd();
		wrap_up();
	end
endmodule : faid_host_tb
`default_nettype wire
